//--- verilog/sdc_cache_regs.vh
/*
  register offsets, field positions, reset values and sizes of the
  segmented disk buffer cache controller.
  assumes: included by the controller file, byte addresses on a 32-bit bus.
*/
`ifndef SDC_CACHE_REGS_VH
`define SDC_CACHE_REGS_VH

// register byte offsets
`define SDC_OFF_CTRL 8'h00
`define SDC_OFF_STATUS 8'h04
`define SDC_OFF_SEGSIZE 8'h08
`define SDC_OFF_PFLIMIT 8'h0C
`define SDC_OFF_CHITS 8'h10
`define SDC_OFF_PHITS 8'h14

// control bits
`define SDC_CTRL_READ_CACHE_DISABLE 0
`define SDC_CTRL_WRITE_CACHE_ENABLE 1
`define SDC_CTRL_READ_AHEAD_DISABLE 2
`define SDC_CTRL_CHK 3

// status bits
`define SDC_ST_BUSY 0
`define SDC_ST_DEFER 1
`define SDC_ST_REJECT 2
`define SDC_ST_PFON 3

// reset values of control bits
`define SDC_RST_READ_CACHE_DISABLE 1'b0
`define SDC_RST_WRITE_CACHE_ENABLE 1'b1
`define SDC_RST_READ_AHEAD_DISABLE 1'b0
`define SDC_RST_CHK 1'b0

// segment size field always reads all ones
`define SDC_SEGSIZE_RD 16'hFFFF

// command codes
`define SDC_OP_READ 2'h0
`define SDC_OP_WRITE 2'h1
`define SDC_OP_SYNC 2'h2

// default sizes
`define SDC_SEG_BLKS 64
`define SDC_PF_BLKS 32

`endif

//--- verilog/sdc_cache.v
/*
  segmented buffer cache controller: segment tag table, read hit search,
  miss fill, prefetch, write retention with early completion, flush on sync,
  avalon-mm register slave with waitrequest.
  assumes: one clock, host command port and medium request port synchronous
  to core_clk_in; the medium answers each request with a one-cycle ack.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdc_cache_regs.vh"

module sdc_cache #(
  parameter LBA_W = 32,
  parameter LEN_W = 16,
  parameter SEG_IW = 2,
  parameter SEG_BLKS = `SDC_SEG_BLKS,
  parameter PF_BLKS = `SDC_PF_BLKS
) (
  // clock and reset
  input wire core_clk_in,
  input wire nrst_in,
  // avalon-mm slave
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // host commands
  input wire cmd_valid_in,
  input wire [1:0] cmd_op_in,
  input wire [LBA_W-1:0] cmd_lba_in,
  input wire [LEN_W-1:0] cmd_len_in,
  output wire cmd_ready_out,
  output reg done_out,
  output reg done_err_out,
  output reg done_hit_out,
  output reg done_pf_hit_out,
  // medium path
  output reg med_req_out,
  output reg med_write_out,
  output reg [LBA_W-1:0] med_lba_out,
  output reg [LEN_W-1:0] med_len_out,
  input wire med_ack_in,
  input wire med_err_in
);

  localparam NSEG = 1 << SEG_IW;
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_LOOK = 3'd1;
  localparam [2:0] S_MED = 3'd2;
  localparam [2:0] S_FLUSH = 3'd3;
  localparam [1:0] K_RD = 2'd0;
  localparam [1:0] K_PF = 2'd1;
  localparam [1:0] K_WR = 2'd2;
  localparam [1:0] K_FL = 2'd3;
  localparam [LEN_W-1:0] SEG_LEN = SEG_BLKS[LEN_W-1:0];
  localparam [LEN_W-1:0] PF_LEN = PF_BLKS[LEN_W-1:0];

  // segment tag table
  reg [LBA_W-1:0] seg_lba_reg [0:NSEG-1];
  reg [LEN_W-1:0] seg_cnt_reg [0:NSEG-1];
  reg [NSEG-1:0] seg_val_reg;
  reg [NSEG-1:0] seg_dirty_reg;
  reg [NSEG-1:0] seg_pf_reg;

  reg [2:0] state_reg;
  reg [1:0] kind_reg;
  reg [1:0] op_reg;
  reg [LBA_W-1:0] lba_reg;
  reg [LEN_W-1:0] len_reg;
  reg [SEG_IW-1:0] vic_reg;
  reg [SEG_IW-1:0] rr_reg;
  reg ret_look_reg;
  reg pf_pred_reg;
  reg [LBA_W-1:0] last_end_reg;
  reg defer_set_reg;
  reg [31:0] hits_reg;
  reg [31:0] pf_hits_reg;

  // bus side state
  reg resp_reg;
  reg read_cache_disable_reg;
  reg write_cache_enable_reg;
  reg read_ahead_disable_reg;
  reg parameter_check_a_reg;
  reg defer_reg;
  reg reject_reg;

  // end address of a block range, one bit wider than an address
  function [LBA_W:0] range_end;
    input [LBA_W-1:0] l;
    input [LEN_W-1:0] n;
    begin
      range_end = {1'b0, l} + {{(LBA_W-LEN_W+1){1'b0}}, n};
    end
  endfunction

  function covers;
    input [LBA_W-1:0] s;
    input [LEN_W-1:0] c;
    input [LBA_W-1:0] l;
    input [LEN_W-1:0] n;
    begin
      covers = (l >= s) && (range_end(l, n) <= range_end(s, c));
    end
  endfunction

  function overlaps;
    input [LBA_W-1:0] s;
    input [LEN_W-1:0] c;
    input [LBA_W-1:0] l;
    input [LEN_W-1:0] n;
    begin
      overlaps = ({1'b0, l} < range_end(s, c)) && ({1'b0, s} < range_end(l, n));
    end
  endfunction

  // a ring keeps only the newest SEG_BLKS blocks of a long transfer
  function [LBA_W-1:0] tail_lba;
    input [LBA_W-1:0] l;
    input [LEN_W-1:0] n;
    begin
      if (n > SEG_LEN) begin
        tail_lba = l + {{(LBA_W-LEN_W){1'b0}}, n - SEG_LEN};
      end else begin
        tail_lba = l;
      end
    end
  endfunction

  function [LEN_W-1:0] tail_cnt;
    input [LEN_W-1:0] n;
    begin
      tail_cnt = (n > SEG_LEN) ? SEG_LEN : n;
    end
  endfunction

  // segment search
  reg hit_found;
  reg [SEG_IW-1:0] hit_idx;
  reg ovl_dirty;
  reg [SEG_IW-1:0] ovl_idx;
  reg flush_any;
  reg [SEG_IW-1:0] flush_idx;
  integer i;
  integer j;

  always @* begin
    hit_found = 1'b0;
    hit_idx = {SEG_IW{1'b0}};
    ovl_dirty = 1'b0;
    ovl_idx = {SEG_IW{1'b0}};
    flush_any = 1'b0;
    flush_idx = {SEG_IW{1'b0}};
    for (i = 0; i < NSEG; i = i + 1) begin
      // with read caching off only prefetched segments may hit
      if (!hit_found && seg_val_reg[i] && (!read_cache_disable_reg || seg_pf_reg[i]) &&
          covers(seg_lba_reg[i], seg_cnt_reg[i], lba_reg, len_reg)) begin
        hit_found = 1'b1;
        hit_idx = i[SEG_IW-1:0];
      end
      if (!ovl_dirty && seg_dirty_reg[i] && overlaps(seg_lba_reg[i], seg_cnt_reg[i], lba_reg, len_reg)) begin
        ovl_dirty = 1'b1;
        ovl_idx = i[SEG_IW-1:0];
      end
      if (!flush_any && seg_dirty_reg[i]) begin
        flush_any = 1'b1;
        flush_idx = i[SEG_IW-1:0];
      end
    end
  end

  assign cmd_ready_out = (state_reg == S_IDLE);

  wire [SEG_IW-1:0] rr_plus = rr_reg + 1'b1;
  wire [LBA_W:0] req_end = range_end(lba_reg, len_reg);

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (j = 0; j < NSEG; j = j + 1) begin
        seg_lba_reg[j] <= {LBA_W{1'b0}};
        seg_cnt_reg[j] <= {LEN_W{1'b0}};
      end
      seg_val_reg <= {NSEG{1'b0}};
      seg_dirty_reg <= {NSEG{1'b0}};
      seg_pf_reg <= {NSEG{1'b0}};
      state_reg <= S_IDLE;
      kind_reg <= K_RD;
      op_reg <= `SDC_OP_READ;
      lba_reg <= {LBA_W{1'b0}};
      len_reg <= {LEN_W{1'b0}};
      vic_reg <= {SEG_IW{1'b0}};
      rr_reg <= {SEG_IW{1'b0}};
      ret_look_reg <= 1'b0;
      pf_pred_reg <= 1'b0;
      last_end_reg <= {LBA_W{1'b0}};
      defer_set_reg <= 1'b0;
      hits_reg <= 32'h0000_0000;
      pf_hits_reg <= 32'h0000_0000;
      done_out <= 1'b0;
      done_err_out <= 1'b0;
      done_hit_out <= 1'b0;
      done_pf_hit_out <= 1'b0;
      med_req_out <= 1'b0;
      med_write_out <= 1'b0;
      med_lba_out <= {LBA_W{1'b0}};
      med_len_out <= {LEN_W{1'b0}};
    end else begin
      done_out <= 1'b0;
      done_err_out <= 1'b0;
      done_hit_out <= 1'b0;
      done_pf_hit_out <= 1'b0;
      defer_set_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (cmd_valid_in) begin
            op_reg <= cmd_op_in;
            lba_reg <= cmd_lba_in;
            len_reg <= cmd_len_in;
            state_reg <= (cmd_op_in == `SDC_OP_SYNC) ? S_FLUSH : S_LOOK;
          end
        end
        S_LOOK: begin
          if (op_reg == `SDC_OP_READ) begin
            if (hit_found) begin
              done_out <= 1'b1;
              done_hit_out <= ~seg_pf_reg[hit_idx];
              done_pf_hit_out <= seg_pf_reg[hit_idx];
              if (seg_pf_reg[hit_idx]) begin
                pf_hits_reg <= pf_hits_reg + 32'h0000_0001;
              end else begin
                hits_reg <= hits_reg + 32'h0000_0001;
              end
              pf_pred_reg <= 1'b1;
              last_end_reg <= req_end[LBA_W-1:0];
              state_reg <= S_IDLE;
            end else if (seg_dirty_reg[rr_reg]) begin
              kind_reg <= K_FL;
              vic_reg <= rr_reg;
              ret_look_reg <= 1'b1;
              med_req_out <= 1'b1;
              med_write_out <= 1'b1;
              med_lba_out <= seg_lba_reg[rr_reg];
              med_len_out <= seg_cnt_reg[rr_reg];
              state_reg <= S_MED;
            end else begin
              kind_reg <= K_RD;
              vic_reg <= rr_reg;
              pf_pred_reg <= (lba_reg == last_end_reg);
              med_req_out <= 1'b1;
              med_write_out <= 1'b0;
              med_lba_out <= lba_reg;
              med_len_out <= len_reg;
              state_reg <= S_MED;
            end
          end else if (ovl_dirty || seg_dirty_reg[rr_reg]) begin
            // commit older dirty data before it can be cleared or reused
            kind_reg <= K_FL;
            vic_reg <= ovl_dirty ? ovl_idx : rr_reg;
            ret_look_reg <= 1'b1;
            med_req_out <= 1'b1;
            med_write_out <= 1'b1;
            med_lba_out <= seg_lba_reg[ovl_dirty ? ovl_idx : rr_reg];
            med_len_out <= seg_cnt_reg[ovl_dirty ? ovl_idx : rr_reg];
            state_reg <= S_MED;
          end else begin
            for (j = 0; j < NSEG; j = j + 1) begin
              if (overlaps(seg_lba_reg[j], seg_cnt_reg[j], lba_reg, len_reg)) begin
                seg_val_reg[j] <= 1'b0;
              end
            end
            vic_reg <= rr_reg;
            if (write_cache_enable_reg && (len_reg <= SEG_LEN)) begin
              seg_lba_reg[rr_reg] <= lba_reg;
              seg_cnt_reg[rr_reg] <= len_reg;
              seg_val_reg[rr_reg] <= ~read_cache_disable_reg;
              seg_dirty_reg[rr_reg] <= 1'b1;
              seg_pf_reg[rr_reg] <= 1'b0;
              rr_reg <= rr_plus;
              done_out <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              kind_reg <= K_WR;
              med_req_out <= 1'b1;
              med_write_out <= 1'b1;
              med_lba_out <= lba_reg;
              med_len_out <= len_reg;
              state_reg <= S_MED;
            end
          end
        end
        S_MED: begin
          if (med_ack_in) begin
            med_req_out <= 1'b0;
            case (kind_reg)
              K_RD: begin
                seg_lba_reg[vic_reg] <= tail_lba(lba_reg, len_reg);
                seg_cnt_reg[vic_reg] <= tail_cnt(len_reg);
                seg_val_reg[vic_reg] <= ~read_cache_disable_reg;
                seg_pf_reg[vic_reg] <= 1'b0;
                rr_reg <= rr_plus;
                done_out <= 1'b1;
                done_err_out <= med_err_in;
                last_end_reg <= req_end[LBA_W-1:0];
                // prefetch length limits from the host are not used
                if (!read_ahead_disable_reg && pf_pred_reg && !seg_dirty_reg[rr_plus]) begin
                  kind_reg <= K_PF;
                  vic_reg <= rr_plus;
                  med_req_out <= 1'b1;
                  med_write_out <= 1'b0;
                  med_lba_out <= req_end[LBA_W-1:0];
                  med_len_out <= PF_LEN;
                end else begin
                  state_reg <= S_IDLE;
                end
              end
              K_PF: begin
                seg_lba_reg[vic_reg] <= med_lba_out;
                seg_cnt_reg[vic_reg] <= med_len_out;
                seg_val_reg[vic_reg] <= ~med_err_in;
                seg_pf_reg[vic_reg] <= 1'b1;
                rr_reg <= vic_reg + 1'b1;
                state_reg <= S_IDLE;
              end
              K_WR: begin
                seg_lba_reg[vic_reg] <= tail_lba(lba_reg, len_reg);
                seg_cnt_reg[vic_reg] <= tail_cnt(len_reg);
                seg_val_reg[vic_reg] <= ~read_cache_disable_reg & ~med_err_in;
                seg_pf_reg[vic_reg] <= 1'b0;
                rr_reg <= rr_plus;
                done_out <= 1'b1;
                done_err_out <= med_err_in;
                state_reg <= S_IDLE;
              end
              default: begin
                seg_dirty_reg[vic_reg] <= 1'b0;
                defer_set_reg <= med_err_in;
                state_reg <= ret_look_reg ? S_LOOK : S_FLUSH;
              end
            endcase
          end
        end
        S_FLUSH: begin
          if (flush_any) begin
            kind_reg <= K_FL;
            vic_reg <= flush_idx;
            ret_look_reg <= 1'b0;
            med_req_out <= 1'b1;
            med_write_out <= 1'b1;
            med_lba_out <= seg_lba_reg[flush_idx];
            med_len_out <= seg_cnt_reg[flush_idx];
            state_reg <= S_MED;
          end else begin
            done_out <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // register slave: one wait cycle per access
  wire bus_req = avs_read_in | avs_write_in;
  wire wr_now = avs_write_in & resp_reg;
  wire st_clr = wr_now && (avs_address_in == `SDC_OFF_STATUS) && avs_byteenable_in[0];
  wire seg_wr = wr_now && (avs_address_in == `SDC_OFF_SEGSIZE) && (avs_byteenable_in[1:0] != 2'b00);

  assign avs_waitrequest_out = bus_req & ~resp_reg;

  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_in)
      `SDC_OFF_CTRL: rd_mux = {28'h000_0000, parameter_check_a_reg, read_ahead_disable_reg, write_cache_enable_reg,
                               read_cache_disable_reg};
      `SDC_OFF_STATUS: rd_mux = {28'h000_0000, pf_pred_reg & ~read_ahead_disable_reg, reject_reg, defer_reg,
                                 state_reg != S_IDLE};
      `SDC_OFF_SEGSIZE: rd_mux = {16'h0000, `SDC_SEGSIZE_RD};
      `SDC_OFF_CHITS: rd_mux = hits_reg;
      `SDC_OFF_PHITS: rd_mux = pf_hits_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      resp_reg <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      read_cache_disable_reg <= `SDC_RST_READ_CACHE_DISABLE;
      write_cache_enable_reg <= `SDC_RST_WRITE_CACHE_ENABLE;
      read_ahead_disable_reg <= `SDC_RST_READ_AHEAD_DISABLE;
      parameter_check_a_reg <= `SDC_RST_CHK;
      defer_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      resp_reg <= bus_req & ~resp_reg;
      if (avs_read_in & ~resp_reg) begin
        avs_readdata_out <= rd_mux;
      end
      // control bits steer caching and prefetch independently
      if (wr_now && (avs_address_in == `SDC_OFF_CTRL) && avs_byteenable_in[0]) begin
        read_cache_disable_reg <= avs_writedata_in[`SDC_CTRL_READ_CACHE_DISABLE];
        write_cache_enable_reg <= avs_writedata_in[`SDC_CTRL_WRITE_CACHE_ENABLE];
        read_ahead_disable_reg <= avs_writedata_in[`SDC_CTRL_READ_AHEAD_DISABLE];
        parameter_check_a_reg <= avs_writedata_in[`SDC_CTRL_CHK];
      end
      // set wins over a write-one-to-clear in the same cycle
      defer_reg <= defer_set_reg | (defer_reg & ~(st_clr & avs_writedata_in[`SDC_ST_DEFER]));
      reject_reg <= (seg_wr & parameter_check_a_reg) |
                    (reject_reg & ~(st_clr & avs_writedata_in[`SDC_ST_REJECT]));
    end
  end

endmodule

`default_nettype wire

//--- tb/sdc_medium_model.sv
/* medium side model: answers each request after a settable delay.
   assumes: the controller holds a request until it sees the ack. */
`timescale 1ns/100ps
`default_nettype none
module sdc_medium_model (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // medium path
  input wire logic med_req_in,
  input wire logic med_write_in,
  input wire logic [31:0] med_lba_in,
  input wire logic [15:0] med_len_in,
  output logic med_ack_out,
  output logic med_err_out,
  // bench control
  input wire logic [7:0] dly_in,
  input wire logic fail_in,
  output logic [48:0] last_out,
  output logic [15:0] cnt_out
);
  logic [7:0] wait_reg;
  logic err_reg;
  logic junk_reg;
  // error line means nothing outside the ack cycle
  assign med_err_out = med_ack_out ? err_reg : junk_reg;
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      med_ack_out <= 1'b0;
      wait_reg <= 8'h0;
      err_reg <= 1'b0;
      junk_reg <= 1'b0;
      last_out <= 49'h0;
      cnt_out <= 16'h0;
    end else begin
      junk_reg <= ~junk_reg;
      if (med_ack_out) begin
        med_ack_out <= 1'b0;
        wait_reg <= 8'h0;
      end else if (med_req_in) begin
        if (wait_reg == 8'h0) begin
          last_out <= {med_write_in, med_lba_in, med_len_in};
          cnt_out <= cnt_out + 16'h1;
        end
        if (wait_reg >= dly_in) begin
          med_ack_out <= 1'b1;
          err_reg <= fail_in & med_write_in;
        end else begin
          wait_reg <= wait_reg + 8'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/sdc_cache_monitor.sv
/* port checker for the segmented buffer cache controller.
   assumes: bound to sdc_cache, single clock domain. */
`timescale 1ns/100ps
`default_nettype none
`include "sdc_cache_regs.vh"
module sdc_cache_monitor #(
  parameter LBA_W = 32,
  parameter LEN_W = 16
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic done_hit_out,
  input wire logic done_pf_hit_out,
  input wire logic med_req_out,
  input wire logic med_write_out,
  input wire logic [LBA_W-1:0] med_lba_out,
  input wire logic [LEN_W-1:0] med_len_out,
  input wire logic med_ack_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic take = cmd_valid_in && cmd_ready_out;
  wire logic rd_ok = avs_read_in && !avs_waitrequest_out;
  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer not one cycle after request");
  seg_ones_a: assert property (rd_ok && avs_address_in == `SDC_OFF_SEGSIZE |-> avs_readdata_out == 32'h0000_ffff)
    else $error("segment size field not all ones");
  pf_fields_a: assert property (rd_ok && avs_address_in == `SDC_OFF_PFLIMIT |-> avs_readdata_out == 32'h0)
    else $error("prefetch limit field not ignored");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  hit_kind_a: assert property (done_hit_out || done_pf_hit_out |-> done_out && !(done_hit_out && done_pf_hit_out))
    else $error("hit flags wrong");
  look_first_a: assert property (take && cmd_op_in == `SDC_OP_READ |=> !med_req_out)
    else $error("medium access before cache lookup");
  req_hold_a: assert property (med_req_out && !med_ack_in |=> med_req_out && $stable({med_write_out, med_lba_out, med_len_out}))
    else $error("medium request changed before ack");
  busy_take_a: assert property (take |=> !cmd_ready_out)
    else $error("ready after command taken");
  done_bound_a: assert property (take |-> ##[1:1000] done_out)
    else $error("command never completed");
  cover property (done_out && done_hit_out);
  cover property (done_out && done_pf_hit_out);
  cover property (med_req_out && med_write_out);
endmodule
bind sdc_cache sdc_cache_monitor #(.LBA_W(LBA_W), .LEN_W(LEN_W)) u_sdc_cache_monitor (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
  .cmd_ready_out(cmd_ready_out), .done_out(done_out), .done_hit_out(done_hit_out),
  .done_pf_hit_out(done_pf_hit_out), .med_req_out(med_req_out), .med_write_out(med_write_out),
  .med_lba_out(med_lba_out), .med_len_out(med_len_out), .med_ack_in(med_ack_in)
);
`default_nettype wire

//--- tb/sdc_cache_tb.sv
/* bench for the segmented buffer cache controller: registers, hits,
   misses, write retention, flush and prefetch.
   assumes: medium model on the far side, one 100 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
`include "sdc_cache_regs.vh"
module sdc_cache_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic vld = 1'b0;
  logic [1:0] op = 2'h0;
  logic [31:0] lba = 32'h0;
  logic [15:0] len = 16'h0;
  logic [7:0] dly = 8'h2;
  logic fail = 1'b0;
  logic [31:0] rdata, mlba;
  logic [15:0] mlen, mcnt, n0;
  logic wreq, rdy, done, derr, hit, pfh, mreq, mwr, mack, merr;
  logic [48:0] last;
  int error_cnt = 0;
  int compares = 0;

  always #5 clk = ~clk;

  sdc_cache u_sdc_cache (
    .core_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .cmd_valid_in(vld), .cmd_op_in(op), .cmd_lba_in(lba), .cmd_len_in(len),
    .cmd_ready_out(rdy), .done_out(done), .done_err_out(derr), .done_hit_out(hit), .done_pf_hit_out(pfh),
    .med_req_out(mreq), .med_write_out(mwr), .med_lba_out(mlba), .med_len_out(mlen),
    .med_ack_in(mack), .med_err_in(merr)
  );
  sdc_medium_model u_sdc_medium_model (
    .core_clk_in(clk), .nrst_in(nrst), .med_req_in(mreq), .med_write_in(mwr), .med_lba_in(mlba),
    .med_len_in(mlen), .med_ack_out(mack), .med_err_out(merr), .dly_in(dly), .fail_in(fail),
    .last_out(last), .cnt_out(mcnt)
  );

  task complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk);
      #1;
    end while (wreq !== 1'b0);
    @(posedge clk);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // e: expected {err, hit, prefetch hit}, m: which of them to compare
  task automatic cmd(input logic [1:0] o, input logic [31:0] l, input logic [15:0] n, input logic [2:0] e,
                     input logic [2:0] m);
    @(posedge clk);
    vld <= 1'b1;
    op <= o;
    lba <= l;
    len <= n;
    #1;
    while (rdy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    vld <= 1'b0;
    #1;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    chk({derr, hit, pfh} & m, e & m);
  endtask

  task automatic rdc(input logic [31:0] l, input logic [15:0] n, input logic [2:0] e);
    cmd(`SDC_OP_READ, l, n, e, 3'h7);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rreg(`SDC_OFF_CTRL, 32'h2);
    rreg(`SDC_OFF_SEGSIZE, 32'hffff);
    wreg(`SDC_OFF_PFLIMIT, 32'h1234_5678);
    rreg(`SDC_OFF_PFLIMIT, 32'h0);
    rreg(8'h40, 32'h0);
    wreg(`SDC_OFF_CTRL, 32'h6);
    wreg(`SDC_OFF_SEGSIZE, 32'h10);
    rreg(`SDC_OFF_STATUS, 32'h0);
    wreg(`SDC_OFF_CTRL, 32'he);
    wreg(`SDC_OFF_SEGSIZE, 32'h10);
    rreg(`SDC_OFF_STATUS, 32'h4);
    rreg(`SDC_OFF_SEGSIZE, 32'hffff);
    wreg(`SDC_OFF_STATUS, 32'h4);
    rreg(`SDC_OFF_STATUS, 32'h0);
    wreg(`SDC_OFF_CTRL, 32'h6);
    n0 = mcnt;
    rdc(32'h100, 16'h8, 3'h0);
    chk(last, {1'b0, 32'h100, 16'h8});
    rdc(32'h100, 16'h8, 3'h2);
    rdc(32'h102, 16'h4, 3'h2);
    chk(mcnt - n0, 16'h1);
    rdc(32'h104, 16'h8, 3'h0);
    cmd(`SDC_OP_WRITE, 32'h100, 16'h8, 3'h0, 3'h7);
    chk(mcnt - n0, 16'h2);
    rdc(32'h100, 16'h8, 3'h2);
    cmd(`SDC_OP_SYNC, 32'h0, 16'h0, 3'h0, 3'h7);
    chk(last, {1'b1, 32'h100, 16'h8});
    rdc(32'h108, 16'h4, 3'h0);
    cmd(`SDC_OP_WRITE, 32'h400, 16'h50, 3'h0, 3'h7);
    chk(last[48], 1'b1);
    rdc(32'h410, 16'h40, 3'h2);
    cmd(`SDC_OP_WRITE, 32'h300, 16'h4, 3'h0, 3'h7);
    fail <= 1'b1;
    cmd(`SDC_OP_SYNC, 32'h0, 16'h0, 3'h0, 3'h7);
    fail <= 1'b0;
    chk(last, {1'b1, 32'h300, 16'h4});
    rreg(`SDC_OFF_STATUS, 32'h2);
    wreg(`SDC_OFF_STATUS, 32'h2);
    rreg(`SDC_OFF_STATUS, 32'h0);
    wreg(`SDC_OFF_CTRL, 32'h7);
    n0 = mcnt;
    rdc(32'h410, 16'h4, 3'h0);
    chk(mcnt - n0, 16'h1);
    rreg(`SDC_OFF_SEGSIZE, 32'hffff);
    rdc(32'h600, 16'h4, 3'h0);
    rdc(32'h604, 16'h4, 3'h0);
    rreg(`SDC_OFF_STATUS, 32'h0);
    chk(mcnt - n0, 16'h3);
    wreg(`SDC_OFF_CTRL, 32'h3);
    dly <= 8'hc;
    rdc(32'h700, 16'h4, 3'h0);
    rdc(32'h704, 16'h4, 3'h0);
    rreg(`SDC_OFF_STATUS, 32'h9);
    chk(last, {1'b0, 32'h708, 16'h20});
    rdc(32'h70a, 16'h4, 3'h1);
    rreg(`SDC_OFF_PHITS, 32'h1);
    rreg(`SDC_OFF_CHITS, 32'h4);
    // long write goes through to the medium and reports its error directly
    fail <= 1'b1;
    cmd(`SDC_OP_WRITE, 32'h800, 16'h50, 3'h4, 3'h7);
    fail <= 1'b0;
    complete_run;
  end

  initial begin
    #200000;
    error_cnt++;
    complete_run;
  end
endmodule
`default_nettype wire
